// ---- rtl/rfgmc_top.v ----
`timescale 1ns/1ns
`include "rfgmc_map.vh"
module rfgmc_top #(
    parameter ATT_W = 32,
    parameter LVL_W = 16
) (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ext_ref_present,
    input wire over_temp,
    output reg ref_lock_en,
    output reg ref_connector_out,
    output reg ref_out_secondary,
    output reg ref_cal_apply,
    output reg fine_synth_en,
    output reg main_synth_en,
    output reg path_main,
    output reg [LVL_W-1:0] level_loop_ref,
    output reg [ATT_W-1:0] atten,
    output reg thermal_mon_en,
    output reg rail_off,
    output reg signed [31:0] freq_offset,
    output reg mod_active,
    output wire irq
);
    // ****************************************
    // registers
    // ****************************************
    reg [31:0] ctrl;
    reg [31:0] freq;
    reg [15:0] fm_n_m1;
    reg [10:0] fm_m;
    reg [15:0] dev;
    reg [9:0] plen;
    reg [9:0] srep;
    reg [15:0] prbs_n;
    reg [9:0] pat_addr;
    reg [3:0] isr;
    reg [3:0] imr;
    reg pat_we;
    reg pat_bit;
    wire rd_setup = psel && !penable;
    wire fm_on = ctrl[`RFGMC_C_FM];
    wire fsk_on = ctrl[`RFGMC_C_FSK] && !fm_on;
    wire [1:0] shape = ctrl[`RFGMC_C_SHAPE_HI:`RFGMC_C_SHAPE_LO];
    wire use_prbs = ctrl[`RFGMC_C_PRBS];
    wire [19:0] pat_span = plen * srep;
    reg mapped;
    reg fm_err;
    reg fsk_err;
    wire cfg_err = fm_err || fsk_err;
    wire fm_run = fm_on && !fm_err;
    wire fsk_run = fsk_on && !fsk_err;
    wire signed [15:0] wave;
    wire wave_wrap;
    wire sym;
    wire pat_wrap;
    wire [3:0] ev;
    wire signed [31:0] fm_prod = wave * $signed({1'b0, dev});
    reg cfg_err_d;
    // ****************************************
    // apb decode: writes take effect on the access edge, reads latch in setup
    // ****************************************
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    always @* begin
        case (paddr)
            `RFGMC_CTRL, `RFGMC_FREQ, `RFGMC_LEVEL, `RFGMC_ATTEN, `RFGMC_FMDIV,
            `RFGMC_FMSAMP, `RFGMC_DEV, `RFGMC_PLEN, `RFGMC_SREP, `RFGMC_PRBSDIV,
            `RFGMC_PADDR, `RFGMC_PDATA, `RFGMC_STATUS, `RFGMC_ISR,
            `RFGMC_IMR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    wire acc_wr = psel && penable && pwrite && mapped;
    always @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup && !pwrite) begin
            case (paddr)
                `RFGMC_CTRL: prdata <= ctrl;
                `RFGMC_FREQ: prdata <= freq;
                `RFGMC_LEVEL: prdata <= {{(32-LVL_W){1'b0}}, level_loop_ref};
                `RFGMC_ATTEN: prdata <= atten[31:0];
                `RFGMC_FMDIV: prdata <= {16'h0000, fm_n_m1};
                `RFGMC_FMSAMP: prdata <= {21'h00_0000, fm_m};
                `RFGMC_DEV: prdata <= {16'h0000, dev};
                `RFGMC_PLEN: prdata <= {22'h00_0000, plen};
                `RFGMC_SREP: prdata <= {22'h00_0000, srep};
                `RFGMC_PRBSDIV: prdata <= {16'h0000, prbs_n};
                `RFGMC_PADDR: prdata <= {22'h00_0000, pat_addr};
                `RFGMC_STATUS: prdata <= {26'h000_0000, mod_active, sym, rail_off,
                                          cfg_err, path_main, ext_ref_present};
                `RFGMC_ISR: prdata <= {28'h000_0000, isr};
                `RFGMC_IMR: prdata <= {28'h000_0000, imr};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
    // ****************************************
    // host writable state, reset to the safe power-on condition
    // ****************************************
    always @(posedge clk) begin
        if (srst) begin
            ctrl <= `RFGMC_CTRL_RST;
            freq <= 32'h0000_0000;
            level_loop_ref <= {LVL_W{1'b0}};
            atten <= {ATT_W{1'b1}};
            fm_n_m1 <= 16'h0000;
            fm_m <= `RFGMC_M_MIN;
            dev <= 16'h0000;
            plen <= 10'h001;
            srep <= 10'h001;
            prbs_n <= 16'h0001;
            pat_addr <= 10'h000;
            imr <= 4'h0;
            pat_we <= 1'b0;
            pat_bit <= 1'b0;
        end else begin
            pat_we <= 1'b0;
            if (acc_wr) begin
                case (paddr)
                    `RFGMC_CTRL: ctrl <= {21'h00_0000, pwdata[10:0]};
                    `RFGMC_FREQ: freq <= pwdata;
                    `RFGMC_LEVEL: level_loop_ref <= pwdata[LVL_W-1:0];
                    `RFGMC_ATTEN: atten <= pwdata[ATT_W-1:0];
                    `RFGMC_FMDIV: fm_n_m1 <= pwdata[15:0];
                    `RFGMC_FMSAMP: fm_m <= pwdata[10:0];
                    `RFGMC_DEV: dev <= pwdata[15:0];
                    `RFGMC_PLEN: plen <= pwdata[9:0];
                    `RFGMC_SREP: srep <= pwdata[9:0];
                    `RFGMC_PRBSDIV: prbs_n <= pwdata[15:0];
                    `RFGMC_PADDR: pat_addr <= pwdata[9:0];
                    `RFGMC_PDATA: begin
                        // auto-increment so a pattern loads as a burst of writes
                        pat_we <= 1'b1;
                        pat_bit <= pwdata[0];
                    end
                    `RFGMC_IMR: imr <= pwdata[3:0];
                    default: ;
                endcase
            end
            if (pat_we)
                pat_addr <= pat_addr + 10'h001;
        end
    end
    // ****************************************
    // setting checks; a bad setting holds the generator off and raises an event
    // ****************************************
    always @* begin
        fm_err = fm_on && (fm_m[0] || fm_m < `RFGMC_M_MIN ||
                 fm_m > ((shape == `RFGMC_SHAPE_SQ) ? `RFGMC_M_MAX_SQ : `RFGMC_M_MAX) ||
                 shape == 2'h3);
        if (!fsk_on)
            fsk_err = 1'b0;
        else if (use_prbs)
            fsk_err = (prbs_n == 16'h0000);
        else
            fsk_err = plen == 10'h000 || plen > `RFGMC_PLEN_MAX || srep == 10'h000 ||
                      fm_n_m1 < `RFGMC_N_MIN_PAT ||
                      pat_span > {10'h000, `RFGMC_PLEN_MAX};
    end
    rfgmc_wave #(
        .N_W(16),
        .M_W(11)
    ) u_wave (
        .clk(clk),
        .srst(srst),
        .en(fm_run),
        .shape(shape),
        .n_m1(fm_n_m1),
        .m(fm_m),
        .wave(wave),
        .wrap(wave_wrap)
    );
    rfgmc_fsk #(
        .N_W(16),
        .DEPTH(1024)
    ) u_fsk (
        .clk(clk),
        .srst(srst),
        .en(fsk_run),
        .use_prbs(use_prbs),
        .n_m1(fm_n_m1),
        .rep(srep),
        .plen(plen),
        .prbs_n(prbs_n),
        .pat_we(pat_we),
        .pat_addr(pat_addr),
        .pat_bit(pat_bit),
        .sym(sym),
        .wrap(pat_wrap)
    );
    // ****************************************
    // relayed controls and modulation output
    // ****************************************
    always @(posedge clk) begin
        if (srst) begin
            ref_lock_en <= 1'b0;
            ref_connector_out <= 1'b0;
            ref_out_secondary <= 1'b0;
            ref_cal_apply <= 1'b0;
            fine_synth_en <= 1'b0;
            main_synth_en <= 1'b0;
            path_main <= 1'b0;
            thermal_mon_en <= 1'b1;
            rail_off <= 1'b0;
            freq_offset <= 32'h0000_0000;
            mod_active <= 1'b0;
            cfg_err_d <= 1'b0;
        end else begin
            // lock only makes sense with a reference present at the connector
            ref_lock_en <= ctrl[`RFGMC_C_REFLOCK] && ext_ref_present;
            ref_connector_out <= ctrl[`RFGMC_C_REFOUT];
            ref_out_secondary <= ctrl[`RFGMC_C_REFOUT2];
            ref_cal_apply <= ctrl[`RFGMC_C_REFLOCK];
            fine_synth_en <= ctrl[`RFGMC_C_FINE];
            main_synth_en <= ctrl[`RFGMC_C_MAIN];
            path_main <= (freq > `RFGMC_PATH_HZ);
            thermal_mon_en <= ctrl[`RFGMC_C_THERM];
            // power stays off until reset, the rails must not bounce back hot
            if (thermal_mon_en && over_temp)
                rail_off <= 1'b1;
            mod_active <= fm_run || fsk_run;
            cfg_err_d <= cfg_err;
            if (fm_run)
                freq_offset <= fm_prod >>> 15;
            else if (fsk_run)
                freq_offset <= sym ? {16'h0000, dev} : -$signed({16'h0000, dev});
            else
                freq_offset <= 32'h0000_0000;
        end
    end
    // ****************************************
    // interrupts: sticky, write one to clear, set wins
    // ****************************************
    assign ev[`RFGMC_EV_WAVE] = wave_wrap;
    assign ev[`RFGMC_EV_PAT] = pat_wrap;
    assign ev[`RFGMC_EV_ERR] = cfg_err && !cfg_err_d;
    assign ev[`RFGMC_EV_HOT] = thermal_mon_en && over_temp && !rail_off;
    always @(posedge clk) begin
        if (srst)
            isr <= 4'h0;
        else if (acc_wr && paddr == `RFGMC_ISR)
            isr <= (isr & ~pwdata[3:0]) | ev;
        else
            isr <= isr | ev;
    end
    assign irq = |(isr & imr);
endmodule

// ---- rtl/rfgmc_map.vh ----
`ifndef RFGMC_MAP_VH
`define RFGMC_MAP_VH
// ****************************************
// register byte offsets
// ****************************************
`define RFGMC_CTRL 8'h00
`define RFGMC_FREQ 8'h04
`define RFGMC_LEVEL 8'h08
`define RFGMC_ATTEN 8'h0C
`define RFGMC_FMDIV 8'h10
`define RFGMC_FMSAMP 8'h14
`define RFGMC_DEV 8'h18
`define RFGMC_PLEN 8'h1C
`define RFGMC_SREP 8'h20
`define RFGMC_PRBSDIV 8'h24
`define RFGMC_PADDR 8'h28
`define RFGMC_PDATA 8'h2C
`define RFGMC_STATUS 8'h30
`define RFGMC_ISR 8'h34
`define RFGMC_IMR 8'h38
// ****************************************
// control fields
// ****************************************
`define RFGMC_C_FM 0
`define RFGMC_C_FSK 1
`define RFGMC_C_SHAPE_LO 2
`define RFGMC_C_SHAPE_HI 3
`define RFGMC_C_PRBS 4
`define RFGMC_C_REFLOCK 5
`define RFGMC_C_REFOUT 6
`define RFGMC_C_REFOUT2 7
`define RFGMC_C_FINE 8
`define RFGMC_C_MAIN 9
`define RFGMC_C_THERM 10
`define RFGMC_CTRL_RST 32'h0000_0400
`define RFGMC_SHAPE_SQ 2'h0
`define RFGMC_SHAPE_SIN 2'h1
`define RFGMC_SHAPE_TRI 2'h2
// ****************************************
// limits and timing
// ****************************************
`define RFGMC_PATH_HZ 32'h02FA_F080
`define RFGMC_M_MIN 11'h00A
`define RFGMC_M_MAX 11'h7F6
`define RFGMC_M_MAX_SQ 11'h3FC
`define RFGMC_PLEN_MAX 10'h3FE
`define RFGMC_N_MIN_PAT 16'h0004
`define RFGMC_CLK_MHZ 50
`define RFGMC_PRBS_MHZ 10
`define RFGMC_PRBS_PRE (`RFGMC_CLK_MHZ / `RFGMC_PRBS_MHZ)
`define RFGMC_EV_WAVE 0
`define RFGMC_EV_PAT 1
`define RFGMC_EV_ERR 2
`define RFGMC_EV_HOT 3
`endif

// ---- rtl/rfgmc_wave.v ----
`timescale 1ns/1ns
`include "rfgmc_map.vh"
module rfgmc_wave #(
    parameter N_W = 16,
    parameter M_W = 11
) (
    input wire clk,
    input wire srst,
    input wire en,
    input wire [1:0] shape,
    input wire [N_W-1:0] n_m1,
    input wire [M_W-1:0] m,
    output reg signed [15:0] wave,
    output reg wrap
);
    reg [N_W-1:0] pre;
    reg [M_W-1:0] idx;
    reg [15:0] phase;
    reg [16:0] recip;
    reg [16:0] rem;
    reg [4:0] dcnt;
    reg ready;
    wire [17:0] trial = {rem[16:0], 1'b0} - {7'h00, m};
    wire tick = ready && (pre == n_m1);
    wire [14:0] q = phase[14:0];
    // inverse kept at 15 bits, a wider context would fill the top with ones
    wire [14:0] q_inv = ~q;
    wire [29:0] para = q * q_inv;
    // square halves counted in samples, phase steps round down and skew the duty
    wire second_half = (idx >= {1'b0, m[M_W-1:1]});
    reg signed [15:0] next_wave;
    // ****************************************
    // phase step 65536/m by a serial divider, so no divider sits in the sample path
    // ****************************************
    always @(posedge clk) begin
        if (srst || !en) begin
            rem <= 17'h0_0001;
            recip <= 17'h0_0000;
            dcnt <= 5'h00;
            ready <= 1'b0;
        end else if (!ready) begin
            if (!trial[17]) begin
                rem <= trial[16:0];
                recip <= {recip[15:0], 1'b1};
            end else begin
                rem <= {rem[15:0], 1'b0};
                recip <= {recip[15:0], 1'b0};
            end
            dcnt <= dcnt + 5'h01;
            if (dcnt == 5'h0F)
                ready <= 1'b1;
        end
    end
    // ****************************************
    // sample clock 50 mhz / n, m samples per period
    // ****************************************
    always @(posedge clk) begin
        if (srst || !ready) begin
            pre <= {N_W{1'b0}};
            idx <= {M_W{1'b0}};
            phase <= 16'h0000;
            wrap <= 1'b0;
        end else begin
            wrap <= 1'b0;
            if (tick) begin
                pre <= {N_W{1'b0}};
                if (idx == m - {{(M_W-1){1'b0}}, 1'b1}) begin
                    idx <= {M_W{1'b0}};
                    phase <= 16'h0000;
                    wrap <= 1'b1;
                end else begin
                    idx <= idx + {{(M_W-1){1'b0}}, 1'b1};
                    phase <= phase + recip[15:0];
                end
            end else begin
                pre <= pre + {{(N_W-1){1'b0}}, 1'b1};
            end
        end
    end
    always @* begin
        case (shape)
            `RFGMC_SHAPE_SQ: next_wave = second_half ? 16'h8001 : 16'h7FFF;
            `RFGMC_SHAPE_SIN: next_wave = phase[15] ? -$signed({1'b0, para[29:15]})
                                                    : $signed({1'b0, para[29:15]});
            `RFGMC_SHAPE_TRI: next_wave = (phase[15] ? {~q, 1'b0} : {q, 1'b0}) - 16'h8000;
            default: next_wave = 16'h0000;
        endcase
    end
    always @(posedge clk) begin
        if (srst || !ready)
            wave <= 16'h0000;
        else
            wave <= next_wave;
    end
endmodule

// ---- rtl/rfgmc_fsk.v ----
`timescale 1ns/1ns
`include "rfgmc_map.vh"
module rfgmc_fsk #(
    parameter N_W = 16,
    parameter DEPTH = 1024
) (
    input wire clk,
    input wire srst,
    input wire en,
    input wire use_prbs,
    input wire [N_W-1:0] n_m1,
    input wire [9:0] rep,
    input wire [9:0] plen,
    input wire [N_W-1:0] prbs_n,
    input wire pat_we,
    input wire [9:0] pat_addr,
    input wire pat_bit,
    output reg sym,
    output reg wrap
);
    reg mem [0:DEPTH-1];
    reg [N_W-1:0] pre;
    reg [9:0] rcnt;
    reg [9:0] bidx;
    reg [2:0] pre10;
    reg [14:0] lfsr;
    wire pat_tick = (pre == n_m1) && (rcnt == rep - 10'h001);
    wire tick10 = (pre10 == `RFGMC_PRBS_PRE - 1);
    always @(posedge clk) begin
        if (pat_we)
            mem[pat_addr] <= pat_bit;
    end
    always @(posedge clk) begin
        if (srst || !en) begin
            pre <= {N_W{1'b0}};
            rcnt <= 10'h000;
            bidx <= 10'h000;
            pre10 <= 3'h0;
            lfsr <= 15'h0001;
            sym <= 1'b0;
            wrap <= 1'b0;
        end else begin
            wrap <= 1'b0;
            if (use_prbs) begin
                // 10 mhz prescale, then divide by n
                pre10 <= tick10 ? 3'h0 : pre10 + 3'h1;
                if (tick10) begin
                    if (pre == prbs_n - {{(N_W-1){1'b0}}, 1'b1}) begin
                        pre <= {N_W{1'b0}};
                        lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
                        sym <= lfsr[14];
                    end else begin
                        pre <= pre + {{(N_W-1){1'b0}}, 1'b1};
                    end
                end
            end else if (pre == n_m1) begin
                pre <= {N_W{1'b0}};
                rcnt <= pat_tick ? 10'h000 : rcnt + 10'h001;
                if (pat_tick) begin
                    sym <= mem[bidx];
                    if (bidx == plen - 10'h001) begin
                        bidx <= 10'h000;
                        wrap <= 1'b1;
                    end else begin
                        bidx <= bidx + 10'h001;
                    end
                end
            end else begin
                pre <= pre + {{(N_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ---- tb/rfgmc_partner.sv ----
`timescale 1ns/1ns
// ****************************************
// analog chain stand-in
// ****************************************
module rfgmc_partner (
    input wire clk,
    input wire ref_on,
    input wire heat,
    output reg ext_ref_present,
    output reg over_temp
);
    initial begin
        ext_ref_present = 1'b0;
        over_temp = 1'b0;
    end
    // detector lags the cable by one clock
    always @(posedge clk) begin
        ext_ref_present <= ref_on;
        over_temp <= heat;
    end
endmodule

// ---- tb/rfgmc_checker.sv ----
`timescale 1ns/1ns
module rfgmc_checker #(
    parameter ATT_W = 32,
    parameter LVL_W = 16
) (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pslverr,
    input wire ext_ref_present,
    input wire over_temp,
    input wire ref_lock_en,
    input wire ref_connector_out,
    input wire ref_out_secondary,
    input wire ref_cal_apply,
    input wire fine_synth_en,
    input wire main_synth_en,
    input wire path_main,
    input wire [LVL_W-1:0] level_loop_ref,
    input wire [ATT_W-1:0] atten,
    input wire thermal_mon_en,
    input wire rail_off,
    input wire signed [31:0] freq_offset,
    input wire mod_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_idle;
        !mod_active [*3];
    endsequence
    sequence s_hot;
        over_temp && thermal_mon_en;
    endsequence
    sequence s_wr;
        psel && penable && pwrite;
    endsequence
    AST_RST_CHAIN: assert property (disable iff (1'b0)
        srst |=> atten == {ATT_W{1'b1}} && level_loop_ref == 0 && thermal_mon_en
        && !fine_synth_en && !main_synth_en && !path_main) else $error("chain reset state");
    AST_RST_REF: assert property (disable iff (1'b0)
        srst |=> !ref_connector_out && !ref_out_secondary && !ref_cal_apply && !ref_lock_en)
        else $error("reference reset state");
    AST_LOCK: assert property (ref_lock_en |-> $past(ext_ref_present))
        else $error("lock without reference");
    AST_NOLOCK: assert property (!ext_ref_present [*2] |-> !ref_lock_en)
        else $error("lock held after reference lost");
    AST_PATH: assert property ($changed(path_main) |->
        $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("path moved without write");
    AST_IDLE: assert property (s_idle |-> freq_offset == 0)
        else $error("offset while idle");
    AST_RAIL: assert property (rail_off |=> rail_off)
        else $error("rail off not sticky");
    AST_HOT: assert property (s_hot |-> ##[1:3] rail_off)
        else $error("no shutdown on trip");
    AST_ERR: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    AST_RAIL_CAUSE: assert property ($rose(rail_off) |-> $past(over_temp, 1) ||
        $past(over_temp, 2) || $past(over_temp, 3)) else $error("rail off without trip");
endmodule
bind rfgmc_top rfgmc_checker #(.ATT_W(ATT_W), .LVL_W(LVL_W)) rfgmc_checker_inst (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pslverr(pslverr), .ext_ref_present(ext_ref_present), .over_temp(over_temp),
    .ref_lock_en(ref_lock_en), .ref_connector_out(ref_connector_out),
    .ref_out_secondary(ref_out_secondary), .ref_cal_apply(ref_cal_apply),
    .fine_synth_en(fine_synth_en), .main_synth_en(main_synth_en), .path_main(path_main),
    .level_loop_ref(level_loop_ref), .atten(atten), .thermal_mon_en(thermal_mon_en),
    .rail_off(rail_off), .freq_offset(freq_offset), .mod_active(mod_active));

// ---- tb/test_rf_generator_modulation_control.sv ----
`timescale 1ns/1ns
`include "rfgmc_map.vh"
module test_rf_generator_modulation_control;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0000_0000;
    reg ref_on = 1'b0;
    reg heat = 1'b0;
    reg [31:0] rs = 32'h0000_c8c2;
    reg [31:0] d;
    reg [39:0] q[$];
    integer error_cnt = 0;
    integer tests_run = 0;
    integer k;
    integer n;
    wire [31:0] prdata;
    wire pready, pslverr, ext_ref_present, over_temp, irq, ref_lock_en, ref_cal_apply;
    wire ref_connector_out, ref_out_secondary, fine_synth_en, main_synth_en, path_main;
    wire thermal_mon_en, rail_off, mod_active;
    wire [15:0] level_loop_ref;
    wire [31:0] atten;
    wire signed [31:0] freq_offset;
    always #10 clk = ~clk;
    rfgmc_partner rfgmc_partner_inst (.clk(clk), .ref_on(ref_on), .heat(heat),
        .ext_ref_present(ext_ref_present), .over_temp(over_temp));
    rfgmc_top rfgmc_top_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_ref_present(ext_ref_present), .over_temp(over_temp),
        .ref_lock_en(ref_lock_en), .ref_connector_out(ref_connector_out),
        .ref_out_secondary(ref_out_secondary), .ref_cal_apply(ref_cal_apply),
        .fine_synth_en(fine_synth_en), .main_synth_en(main_synth_en), .path_main(path_main),
        .level_loop_ref(level_loop_ref), .atten(atten), .thermal_mon_en(thermal_mon_en),
        .rail_off(rail_off), .freq_offset(freq_offset), .mod_active(mod_active), .irq(irq));
    function [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic check(input [31:0] seen, input [31:0] exp, input string what);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input w, input [7:0] a, input [31:0] v);
        integer t;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        @(posedge clk);
        while (pready !== 1'b1) begin
            t = t + 1;
            if (t > 50) begin
                error_cnt = error_cnt + 1;
                finish_test();
            end
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input [7:0] a, input [31:0] v);
        apb(1'b1, a, v);
    endtask
    task automatic rd(input [7:0] a, input [31:0] e);
        q.push_back({a, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic tick(input integer c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // cycles until freq_offset moves, or until it equals v when hunt is set
    task automatic wait_chg(input hunt, input [31:0] v, output integer c);
        reg [31:0] o;
        o = freq_offset;
        c = 0;
        do begin
            tick(1);
            c = c + 1;
            if (c > 3000) begin
                error_cnt = error_cnt + 1;
                finish_test();
            end
        end while (hunt ? freq_offset !== v : freq_offset === o);
    endtask
    task automatic trymod(input [31:0] ctrl, input e);
        wr(`RFGMC_CTRL, ctrl);
        tick(40);
        check(mod_active, e, "mod_active");
        wr(`RFGMC_CTRL, `RFGMC_CTRL_RST);
    endtask
    // read data is checked at the completing edge of the access phase
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            check(pslverr, paddr > `RFGMC_IMR, "pslverr");
            if (!pwrite) check(prdata, q.pop_front() & 32'hFFFF_FFFF, "prdata");
        end
    end
    initial begin
        tick(6);
        srst <= 1'b0;
        tick(1);
        check(atten, 32'hFFFF_FFFF, "atten");
        check(level_loop_ref, 32'h0000_0000, "level");
        check({ref_connector_out, ref_out_secondary, ref_cal_apply}, 0, "ref");
        check({fine_synth_en, main_synth_en, path_main}, 0, "synth");
        check(thermal_mon_en, 1, "thermal");
        rd(`RFGMC_CTRL, `RFGMC_CTRL_RST);
        rd(8'h3C, 32'h0000_0000);
        d = rnd();
        wr(`RFGMC_LEVEL, d);
        rd(`RFGMC_LEVEL, d & 32'h0000_FFFF);
        check(level_loop_ref, d & 32'h0000_FFFF, "level");
        d = rnd();
        wr(`RFGMC_ATTEN, d);
        rd(`RFGMC_ATTEN, d);
        for (k = 0; k < 3; k = k + 1) begin
            d = (k == 2) ? rnd() % `RFGMC_PATH_HZ : `RFGMC_PATH_HZ + k;
            wr(`RFGMC_FREQ, d);
            tick(2);
            check(path_main, d > `RFGMC_PATH_HZ, "path_main");
        end
        ref_on <= 1'b1;
        wr(`RFGMC_CTRL, 32'h0000_07E0);
        tick(3);
        check({ref_lock_en, ref_cal_apply, fine_synth_en, main_synth_en}, 4'hF, "lock");
        check({ref_connector_out, ref_out_secondary}, 2'h3, "refout");
        ref_on <= 1'b0;
        tick(4);
        check(ref_lock_en, 0, "lock");
        wr(`RFGMC_CTRL, `RFGMC_CTRL_RST);
        d = 32'h0000_0001 + rnd() % 32'h0000_0100;
        wr(`RFGMC_DEV, d);
        wr(`RFGMC_FMDIV, 32'h0000_0004);
        wr(`RFGMC_SREP, 32'h0000_0001);
        wr(`RFGMC_PLEN, 32'h0000_0003);
        wr(`RFGMC_PADDR, 32'h0000_0000);
        for (k = 0; k < 3; k = k + 1) wr(`RFGMC_PDATA, k == 0);
        wr(`RFGMC_IMR, 32'h0000_0002);
        wr(`RFGMC_CTRL, 32'h0000_0402);
        wait_chg(1'b1, d, n);
        tick(2);
        for (k = 1; k < 7; k = k + 1) begin
            tick(5);
            check(freq_offset, (k % 3 == 0) ? d : -d, "fsk");
        end
        check(irq, 1, "irq");
        wr(`RFGMC_CTRL, `RFGMC_CTRL_RST);
        wr(`RFGMC_ISR, 32'h0000_0002);
        tick(1);
        check(irq, 0, "irq");
        wr(`RFGMC_FMDIV, 32'h0000_0003);
        wr(`RFGMC_IMR, 32'h0000_0004);
        trymod(32'h0000_0402, 0);
        check(irq, 1, "irq");
        wr(`RFGMC_ISR, 32'h0000_0004);
        tick(1);
        check(irq, 0, "irq");
        wr(`RFGMC_FMDIV, 32'h0000_0004);
        wr(`RFGMC_SREP, 32'h0000_0155);
        trymod(32'h0000_0402, 0);
        wr(`RFGMC_SREP, 32'h0000_0154);
        trymod(32'h0000_0402, 1);
        wr(`RFGMC_FMSAMP, `RFGMC_M_MAX_SQ);
        trymod(32'h0000_0401, 1);
        wr(`RFGMC_FMSAMP, `RFGMC_M_MAX_SQ + 2);
        trymod(32'h0000_0401, 0);
        trymod(32'h0000_0405, 1);
        wr(`RFGMC_FMSAMP, `RFGMC_M_MAX);
        trymod(32'h0000_0409, 1);
        wr(`RFGMC_FMSAMP, `RFGMC_M_MAX + 2);
        trymod(32'h0000_0405, 0);
        wr(`RFGMC_FMSAMP, `RFGMC_M_MIN + 1);
        trymod(32'h0000_0409, 0);
        wr(`RFGMC_FMSAMP, `RFGMC_M_MIN);
        trymod(32'h0000_040D, 0);
        d = 32'h0000_1000 + rnd() % 32'h0000_1000;
        wr(`RFGMC_DEV, d);
        wr(`RFGMC_IMR, 32'h0000_0001);
        for (k = 0; k < 2; k = k + 1) begin
            wr(`RFGMC_FMDIV, 50 * k + 49); // 100 khz and 50 khz
            wr(`RFGMC_CTRL, 32'h0000_0401);
            wait_chg(1'b0, 0, n);
            wait_chg(1'b0, 0, n);
            check(n, 250 * (k + 1), "fm_half");
            wait_chg(1'b0, 0, n);
            check(n, 250 * (k + 1), "fm_half");
            check(irq, 1, "irq");
            wr(`RFGMC_CTRL, `RFGMC_CTRL_RST);
            wr(`RFGMC_ISR, 32'h0000_0001);
        end
        wr(`RFGMC_PRBSDIV, 32'h0000_0002);
        wr(`RFGMC_CTRL, 32'h0000_0412);
        wait_chg(1'b0, 0, n);
        for (k = 0; k < 6; k = k + 1) begin
            wait_chg(1'b0, 0, n);
            check(n % (`RFGMC_PRBS_PRE * 2), 0, "prbs");
        end
        wr(`RFGMC_CTRL, `RFGMC_CTRL_RST);
        wr(`RFGMC_IMR, 32'h0000_0008);
        heat <= 1'b1;
        tick(6);
        check({rail_off, irq}, 2'h3, "thermal");
        finish_test();
    end
endmodule
